// ### design/sdram_cfg_device.sv
// Device end: configuration words, burst column sequencing and read latency.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Base word: length, type, latency, mode, write.
// - Load command captures base word; held.
// - Controller loads only idle, then waits.
// - Bank bits 1/0 = 10 write extra word.
// - Extra word defaults: sensor, full drive, banks.
// - Extra word holds refresh, array, drive settings.
// - Lengths 1,2,4,8; full page sequential only.
// - Burst length caps columns per command.
// - Full page runs until burst terminate.
// - Burst wraps inside aligned column block.
// - Full page wraps to column zero.
// - Sequential adds beat; interleaved XORs beat.
// - Read latency two or three clocks.
// - Drive from n+m-1, valid at n+m.
// - Normal operation only with mode bits zero.
// - Write single bit makes writes one location.
// - Controller never programs reserved encodings.
module sdram_cfg_device #(
  parameter int DQ_W  = 16,
  parameter int COL_W = 9
) (
  input  wire logic         REF_CLK,
  input  wire logic         RESET,
  sdram_link_if.device      link,
  output logic [12:0]       BASE_CONFIG,
  output logic [12:0]       EXTRA_CONFIG,
  output logic              NORMAL_MODE,
  output logic              BURST_BUSY,
  output logic [COL_W-1:0]  BURST_COLUMN
);

  if (COL_W < 4 || COL_W > 10 || DQ_W < 1) begin : g_bad_param
    $error("sdram_cfg_device: COL_W must be 4..10 and DQ_W positive.");
  end

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_WAIT  = 4'b0010,
    ST_READ  = 4'b0100,
    ST_WRITE = 4'b1000
  } state_t;

  localparam logic [COL_W-1:0] COL_ONE = COL_W'(1);

  state_t           st_q;
  state_t           st_d;
  logic [12:0]      base_q;
  logic [12:0]      ext_q;
  logic [COL_W-1:0] start_q;
  logic [COL_W-1:0] beat_q;
  logic [COL_W-1:0] beat_d;
  logic [DQ_W-1:0]  dq_q;
  logic             oe_q;
  logic             normal_q;
  logic             busy_q;
  logic [COL_W-1:0] col_out_q;
  logic [DQ_W-1:0]  mem_q [2**COL_W];

  // Column of a beat inside the aligned block of the burst.
  function automatic logic [COL_W-1:0] col_at(
      input logic [COL_W-1:0] start,
      input logic [COL_W-1:0] beat,
      input logic [COL_W-1:0] mask,
      input logic             ilv);
    logic [COL_W-1:0] off;
    off = ilv ? (start ^ beat) : (start + beat);
    return (start & ~mask) | (off & mask);
  endfunction

  // Command decode straight off the link; same clock, no synchroniser.
  wire       sel      = !link.cs_n;
  wire [2:0] pins     = {link.ras_n, link.cas_n, link.we_n};
  wire       is_load  = sel && (pins == sdram_cfg_pkg::PIN_LOAD);
  wire       is_read  = sel && (pins == sdram_cfg_pkg::PIN_READ);
  wire       is_write = sel && (pins == sdram_cfg_pkg::PIN_WRITE);
  wire       is_term  = sel && (pins == sdram_cfg_pkg::PIN_TERM);
  wire       load_base = is_load && (link.ba == sdram_cfg_pkg::BA_BASE);
  wire       load_ext  = is_load && (link.ba == sdram_cfg_pkg::BA_EXT);

  // Field decode of the held base word.
  wire [2:0] bl_code =
    base_q[sdram_cfg_pkg::BL_LSB +: sdram_cfg_pkg::BL_W];
  wire       ilv     = base_q[sdram_cfg_pkg::BT_BIT];
  wire [2:0] lat_fld = base_q[sdram_cfg_pkg::LAT_LSB +: sdram_cfg_pkg::LAT_W];
  wire       lat3    = (lat_fld == sdram_cfg_pkg::LAT_3);
  wire       wsingle = base_q[sdram_cfg_pkg::WSB_BIT];
  wire       normal  = (base_q[sdram_cfg_pkg::OPM_LSB +: sdram_cfg_pkg::OPM_W]
                        == 2'h0);

  // Interleaved full page is unsupported and falls back to single beats.
  wire [3:0]       beats   = sdram_cfg_pkg::burst_beats(bl_code, ilv);
  wire             full    = (beats == 4'h0);
  wire [COL_W-1:0] beats_c = COL_W'(beats);
  wire [COL_W-1:0] mask    = full ? '1 : (beats_c - COL_ONE);
  wire             last    = !full && (beat_q == beats_c - COL_ONE);
  wire [COL_W-1:0] col_now = col_at(start_q, beat_q, mask, ilv);
  wire [COL_W-1:0] cmd_col = link.addr[COL_W-1:0];

  // A write burst only continues past its first beat when it has more.
  wire wr_more = normal && !wsingle && (full || beats > 4'h1);

  always_comb begin
    st_d   = st_q;
    beat_d = beat_q;
    case (st_q)
      ST_IDLE: begin
        st_d = ST_IDLE;
      end
      ST_WAIT: begin
        st_d = ST_READ;
      end
      ST_READ: begin
        beat_d = beat_q + COL_ONE;
        if (last) begin
          st_d = ST_IDLE;
        end
      end
      ST_WRITE: begin
        beat_d = beat_q + COL_ONE;
        if (last) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    // A new read or write cuts any burst short, a terminate simply ends it.
    if (is_term) begin
      st_d = ST_IDLE;
    end else if (is_read && normal) begin
      st_d   = lat3 ? ST_WAIT : ST_READ;
      beat_d = '0;
    end else if (is_write && normal) begin
      st_d   = wr_more ? ST_WRITE : ST_IDLE;
      beat_d = COL_ONE;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      st_q   <= ST_IDLE;
      beat_q <= '0;
    end else begin
      st_q   <= st_d;
      beat_q <= beat_d;
    end
  end

  // The base word only changes on a load; power loss is reset here.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      base_q <= sdram_cfg_pkg::BASE_RESET;
      ext_q  <= sdram_cfg_pkg::EXT_RESET;
    end else begin
      if (load_base) begin
        base_q <= link.addr;
      end
      if (load_ext) begin
        ext_q <= link.addr;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      start_q <= '0;
    end else if ((is_read || is_write) && !is_term) begin
      start_q <= cmd_col;
    end
  end

  // Read data leave one edge after their column is addressed, so the
  // extra wait state alone makes the difference between latencies.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      dq_q <= '0;
      oe_q <= 1'b0;
    end else begin
      dq_q <= mem_q[col_now];
      oe_q <= (st_q == ST_READ);
    end
  end

  // The first write beat arrives with the command itself.
  always_ff @(posedge REF_CLK) begin
    if (is_write && normal) begin
      mem_q[cmd_col] <= link.dq;
    end else if (st_q == ST_WRITE && !is_term && !is_read) begin
      mem_q[col_now] <= link.dq;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      normal_q  <= 1'b1;
      busy_q    <= 1'b0;
      col_out_q <= '0;
    end else begin
      normal_q  <= load_base ?
                   (link.addr[sdram_cfg_pkg::OPM_LSB +: sdram_cfg_pkg::OPM_W]
                    == 2'h0) : normal;
      busy_q    <= (st_d != ST_IDLE);
      col_out_q <= col_now;
    end
  end

  assign link.dq_dev  = dq_q;
  assign link.oe_dev  = oe_q;
  assign BASE_CONFIG  = base_q;
  assign EXTRA_CONFIG = ext_q;
  assign NORMAL_MODE  = normal_q;
  assign BURST_BUSY   = busy_q;
  assign BURST_COLUMN = col_out_q;

endmodule
`default_nettype wire

// ### design/sdram_cfg_host.sv
// Controller end: register port commands driven onto the device link.
`timescale 1ns/10ps
`default_nettype none
module sdram_cfg_host #(
  parameter int DQ_W = 16
) (
  input  wire logic         REF_CLK,
  input  wire logic         RESET,
  input  wire logic [3:0]   ADDR,
  input  wire logic [31:0]  WDATA,
  input  wire logic         WR,
  input  wire logic         RD,
  output logic [31:0]       RDATA,
  sdram_link_if.host        link
);

  if (DQ_W < 1 || DQ_W > 16) begin : g_bad_param
    $error("sdram_cfg_host: DQ_W must be 1..16.");
  end

  logic [3:0]      pins_q;
  logic [1:0]      ba_q;
  logic [12:0]     addr_q;
  logic [DQ_W-1:0] wdata_q;
  logic [DQ_W-1:0] dq_q;
  logic            oe_q;
  logic [12:0]     mirror_q;
  logic [1:0]      mrd_q;
  logic [3:0]      wleft_q;
  logic            wrun_q;
  logic [1:0]      rwait_q;
  logic [3:0]      rleft_q;
  logic            rrun_q;
  logic [DQ_W-1:0] rdata_q;
  logic            rvalid_q;
  logic [7:0]      rcount_q;
  logic            err_q;
  logic [31:0]     rdout_q;

  wire        cmd_wr = WR && (ADDR == sdram_cfg_pkg::REG_CMD);
  wire [2:0]  op     = WDATA[sdram_cfg_pkg::CMD_OP_LSB +: 3];
  wire [1:0]  ba     = WDATA[sdram_cfg_pkg::CMD_BA_LSB +: 2];
  wire [12:0] word   = WDATA[12:0];

  wire [3:0] beats = sdram_cfg_pkg::burst_beats(
                       mirror_q[sdram_cfg_pkg::BL_LSB +: sdram_cfg_pkg::BL_W],
                       mirror_q[sdram_cfg_pkg::BT_BIT]);
  wire       lat3  = (mirror_q[sdram_cfg_pkg::LAT_LSB +: sdram_cfg_pkg::LAT_W]
                      == sdram_cfg_pkg::LAT_3);
  wire       wsing = mirror_q[sdram_cfg_pkg::WSB_BIT];
  wire       busy  = (mrd_q != 2'h0) || wrun_q || rrun_q;

  // Reserved encodings and reserved bank selections are never sent.
  wire load_bad = (ba == sdram_cfg_pkg::BA_BASE) ?
                    !sdram_cfg_pkg::base_word_ok(word) :
                  (ba == sdram_cfg_pkg::BA_EXT) ?
                    (word[12:sdram_cfg_pkg::EXT_RSV_LSB] != 6'h00) :
                    1'b1;
  wire is_term  = (op == sdram_cfg_pkg::OP_TERM);
  wire refuse   = cmd_wr && ((busy && !is_term) ||
                  ((op == sdram_cfg_pkg::OP_LOAD) && load_bad) ||
                  (op > sdram_cfg_pkg::OP_PRECH));
  wire accept   = cmd_wr && !refuse;
  wire go_load  = accept && (op == sdram_cfg_pkg::OP_LOAD);
  wire go_read  = accept && (op == sdram_cfg_pkg::OP_READ);
  wire go_write = accept && (op == sdram_cfg_pkg::OP_WRITE);
  wire go_term  = accept && is_term;
  wire capture  = rrun_q && (rwait_q == 2'h0);

  wire [3:0] op_pins =
    (op == sdram_cfg_pkg::OP_ACTIVE) ? {1'b0, sdram_cfg_pkg::PIN_ACTIVE} :
    (op == sdram_cfg_pkg::OP_READ)   ? {1'b0, sdram_cfg_pkg::PIN_READ} :
    (op == sdram_cfg_pkg::OP_WRITE)  ? {1'b0, sdram_cfg_pkg::PIN_WRITE} :
    (op == sdram_cfg_pkg::OP_LOAD)   ? {1'b0, sdram_cfg_pkg::PIN_LOAD} :
    (op == sdram_cfg_pkg::OP_TERM)   ? {1'b0, sdram_cfg_pkg::PIN_TERM} :
    (op == sdram_cfg_pkg::OP_PRECH)  ? {1'b0, sdram_cfg_pkg::PIN_PRECH} :
    {1'b1, sdram_cfg_pkg::PIN_NOP};

  wire [31:0] rd_mux =
    (ADDR == sdram_cfg_pkg::REG_WDATA)  ? 32'(wdata_q) :
    (ADDR == sdram_cfg_pkg::REG_STATUS) ? {8'h00, rcount_q, 12'h000,
                                           rrun_q, rvalid_q, err_q, busy} :
    (ADDR == sdram_cfg_pkg::REG_RDATA)  ? 32'(rdata_q) : 32'h0000_0000;

  // Link command stands for exactly one cycle, then the chip is deselected.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      pins_q <= {1'b1, sdram_cfg_pkg::PIN_NOP};
      ba_q   <= 2'h0;
      addr_q <= 13'h0000;
    end else begin
      pins_q <= accept ? op_pins : {1'b1, sdram_cfg_pkg::PIN_NOP};
      ba_q   <= accept ? ba : ba_q;
      addr_q <= accept ? word : addr_q;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      wdata_q  <= '0;
      mirror_q <= sdram_cfg_pkg::BASE_RESET;
      mrd_q    <= 2'h0;
    end else begin
      if (WR && ADDR == sdram_cfg_pkg::REG_WDATA) begin
        wdata_q <= WDATA[DQ_W-1:0];
      end
      if (go_load && ba == sdram_cfg_pkg::BA_BASE) begin
        mirror_q <= word;
      end
      mrd_q <= go_load ? 2'(sdram_cfg_pkg::MRD_CYCLES) :
               (mrd_q != 2'h0) ? mrd_q - 2'h1 : 2'h0;
    end
  end

  // Write beats count up from the stored word; full page runs until stopped.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      dq_q    <= '0;
      oe_q    <= 1'b0;
      wrun_q  <= 1'b0;
      wleft_q <= 4'h0;
    end else if (go_write) begin
      dq_q    <= wdata_q;
      oe_q    <= 1'b1;
      wrun_q  <= !wsing && (beats != 4'h1);
      wleft_q <= (beats == 4'h0) ? 4'h0 : beats - 4'h1;
    end else if (go_term || (wrun_q && wleft_q == 4'h1)) begin
      oe_q    <= wrun_q && !go_term;
      dq_q    <= dq_q + DQ_W'(1);
      wrun_q  <= 1'b0;
    end else begin
      oe_q    <= wrun_q;
      dq_q    <= wrun_q ? dq_q + DQ_W'(1) : dq_q;
      wleft_q <= (wrun_q && wleft_q != 4'h0) ? wleft_q - 4'h1 : wleft_q;
    end
  end

  // First beat is sampled latency plus one edges after the command leaves.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      rrun_q   <= 1'b0;
      rwait_q  <= 2'h0;
      rleft_q  <= 4'h0;
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
      rcount_q <= 8'h00;
    end else if (go_read) begin
      rrun_q   <= 1'b1;
      rwait_q  <= lat3 ? 2'h3 : 2'h2;
      rleft_q  <= beats;
      rvalid_q <= 1'b0;
      rcount_q <= 8'h00;
    end else if (go_term) begin
      rrun_q   <= 1'b0;
    end else if (capture) begin
      rdata_q  <= link.dq;
      rvalid_q <= 1'b1;
      rcount_q <= rcount_q + 8'h01;
      rleft_q  <= (rleft_q == 4'h0) ? 4'h0 : rleft_q - 4'h1;
      rrun_q   <= (rleft_q != 4'h1);
    end else if (rrun_q) begin
      rwait_q  <= rwait_q - 2'h1;
    end
  end

  // A refusal flag raised in the same cycle as a clear stays raised.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      err_q   <= 1'b0;
      rdout_q <= 32'h0000_0000;
    end else begin
      err_q   <= refuse ? 1'b1 : (accept ? 1'b0 : err_q);
      rdout_q <= RD ? rd_mux : 32'h0000_0000;
    end
  end

  assign link.cs_n    = pins_q[3];
  assign link.ras_n   = pins_q[2];
  assign link.cas_n   = pins_q[1];
  assign link.we_n    = pins_q[0];
  assign link.ba      = ba_q;
  assign link.addr    = addr_q;
  assign link.dq_host = dq_q;
  assign link.oe_host = oe_q;
  assign RDATA        = rdout_q;

endmodule
`default_nettype wire

// ### design/sdram_cfg_pkg.sv
// Shared constants, encodings and helpers for the configuration and burst link.
package sdram_cfg_pkg;

  localparam int ADDR_W = 13;
  localparam int BA_W   = 2;
  localparam int CFG_W  = 13;

  // Base configuration word fields.
  localparam int BL_LSB  = 0;
  localparam int BL_W    = 3;
  localparam int BT_BIT  = 3;
  localparam int LAT_LSB = 4;
  localparam int LAT_W   = 3;
  localparam int OPM_LSB = 7;
  localparam int OPM_W   = 2;
  localparam int WSB_BIT = 9;
  localparam int RSV_LSB = 10;

  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] LAT_2   = 3'h2;
  localparam logic [2:0] LAT_3   = 3'h3;

  // Base word after reset: length 1, sequential, latency 2, normal mode.
  localparam logic [12:0] BASE_RESET = 13'h0020;

  // Extra low-power configuration word fields.
  localparam int ARR_SR_LSB  = 0;
  localparam int ARR_SR_W    = 3;
  localparam int TMP_SR_LSB  = 3;
  localparam int TMP_SR_W    = 2;
  localparam int DS_LSB      = 5;
  localparam int DS_W        = 2;
  localparam int EXT_RSV_LSB = 7;
  // All zero: temperature sensor on, full drive, all four banks refreshed.
  localparam logic [12:0] EXT_RESET = 13'h0000;

  localparam logic [1:0] BA_BASE = 2'h0;
  localparam logic [1:0] BA_EXT  = 2'h2;

  // Pin codes {ras_n, cas_n, we_n} with chip select low.
  localparam logic [2:0] PIN_LOAD   = 3'h0;
  localparam logic [2:0] PIN_PRECH  = 3'h2;
  localparam logic [2:0] PIN_ACTIVE = 3'h3;
  localparam logic [2:0] PIN_WRITE  = 3'h4;
  localparam logic [2:0] PIN_READ   = 3'h5;
  localparam logic [2:0] PIN_TERM   = 3'h6;
  localparam logic [2:0] PIN_NOP    = 3'h7;

  // Host command opcodes.
  localparam logic [2:0] OP_NOP    = 3'h0;
  localparam logic [2:0] OP_ACTIVE = 3'h1;
  localparam logic [2:0] OP_READ   = 3'h2;
  localparam logic [2:0] OP_WRITE  = 3'h3;
  localparam logic [2:0] OP_LOAD   = 3'h4;
  localparam logic [2:0] OP_TERM   = 3'h5;
  localparam logic [2:0] OP_PRECH  = 3'h6;

  // Host register offsets and command word layout.
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_WDATA  = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_RDATA  = 4'hC;
  localparam int CMD_BA_LSB = 13;
  localparam int CMD_OP_LSB = 16;

  // Wait after a configuration load.
  localparam int CLK_PERIOD_NS = 100;
  localparam int TMRD_NS       = 20;
  localparam int MRD_CYCLES    = (TMRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Beats in one burst; zero means a full page that runs until terminated.
  function automatic logic [3:0] burst_beats(input logic [2:0] code,
                                             input logic       ilv);
    case (code)
      BL_1:    return 4'h1;
      BL_2:    return 4'h2;
      BL_4:    return 4'h4;
      BL_8:    return 4'h8;
      BL_FULL: return ilv ? 4'h1 : 4'h0;
      default: return 4'h1;
    endcase
  endfunction

  function automatic logic base_word_ok(input logic [12:0] w);
    logic [3:0] bl;
    bl = burst_beats(w[BL_LSB +: BL_W], w[BT_BIT]);
    return (w[12:RSV_LSB] == 3'h0) && (w[OPM_LSB +: OPM_W] == 2'h0) &&
           (w[LAT_LSB +: LAT_W] inside {LAT_2, LAT_3}) &&
           ((w[BL_LSB +: BL_W] <= BL_8) ||
            ((w[BL_LSB +: BL_W] == BL_FULL) && (bl == 4'h0)));
  endfunction

endpackage

// ### design/sdram_link_if.sv
// Command, address and data link between the memory controller and the device.
`timescale 1ns/10ps
`default_nettype none
interface sdram_link_if #(parameter int DQ_W = 16);
  logic            cs_n;
  logic            ras_n;
  logic            cas_n;
  logic            we_n;
  logic [1:0]      ba;
  logic [12:0]     addr;
  logic [DQ_W-1:0] dq_host;
  logic            oe_host;
  logic [DQ_W-1:0] dq_dev;
  logic            oe_dev;
  logic [DQ_W-1:0] dq;

  // Shared data wire; an undriven bus reads as zero.
  assign dq = oe_host ? dq_host : (oe_dev ? dq_dev : '0);

  modport device (input cs_n, ras_n, cas_n, we_n, ba, addr, dq,
                  output dq_dev, oe_dev);
  modport host (output cs_n, ras_n, cas_n, we_n, ba, addr, dq_host, oe_host,
                input dq);
endinterface
`default_nettype wire

// ### dv/sdram_link_assertions.sv
// Concurrent checks on the link between the controller and device ends.
`timescale 1ns/10ps
`default_nettype none
module sdram_link_assertions (
  input wire logic        REF_CLK,
  input wire logic        RESET,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [1:0]  ba,
  input wire logic [12:0] addr,
  input wire logic        oe_host,
  input wire logic        oe_dev
);
  logic        rd;
  logic        wr;
  logic        ld;
  logic        tm;
  logic [3:0]  len;
  logic [12:0] cfg_q;
  logic [3:0]  rcnt_q;
  logic [3:0]  wcnt_q;

  assign rd = !cs_n && ras_n && !cas_n && we_n;
  assign wr = !cs_n && ras_n && !cas_n && !we_n;
  assign ld = !cs_n && !ras_n && !cas_n && !we_n;
  assign tm = !cs_n && ras_n && cas_n && !we_n;
  assign len = 4'h1 << cfg_q[1:0];

  // The checker keeps its own copy of the base word from the wire, so a
  // device that stores the word wrongly cannot mask its own timing.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      cfg_q <= sdram_cfg_pkg::BASE_RESET;
      rcnt_q <= 4'h0;
      wcnt_q <= 4'h0;
    end else begin
      if (ld && ba == sdram_cfg_pkg::BA_BASE) cfg_q <= addr;
      rcnt_q <= oe_dev ? rcnt_q + 4'h1 : 4'h0;
      wcnt_q <= oe_host ? wcnt_q + 4'h1 : 4'h0;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  sequence s_first_two;
    !oe_dev ##1 oe_dev;
  endsequence
  sequence s_first_three;
    !oe_dev ##1 s_first_two;
  endsequence

  a_lat_two: assert property (rd && !oe_dev && cfg_q[6:4] == 3'h2
    |=> s_first_two) else $error("read data late or early at latency two");
  a_lat_three: assert property (rd && !oe_dev && cfg_q[6:4] == 3'h3
    |=> s_first_three) else $error("read data wrong at latency three");
  a_read_beats: assert property ($fell(oe_dev) && rcnt_q != 4'h0
    && cfg_q[2:0] != 3'h7 |-> rcnt_q == len)
    else $error("read burst beat count differs from length");
  a_write_beats: assert property ($fell(oe_host) && wcnt_q != 4'h0
    && !cfg_q[9] && cfg_q[2:0] != 3'h7 |-> wcnt_q == len)
    else $error("write burst beat count differs from length");
  a_bus_exclusive: assert property (!(oe_host && oe_dev))
    else $error("both ends drive the data wire");
  a_write_beat0: assert property (wr |-> oe_host)
    else $error("first write beat missing at command edge");
  a_load_idle: assert property (ld |-> !oe_dev && !oe_host)
    else $error("configuration load during a burst");
  a_load_gap: assert property (ld |=> cs_n)
    else $error("command right after a configuration load");
  a_bank_legal: assert property (ld |-> ba == 2'h0 || ba == 2'h2)
    else $error("configuration load with reserved bank select");
  a_base_legal: assert property (ld && ba == 2'h0 |->
    addr[12:10] == 3'h0 && addr[8:7] == 2'h0 &&
    (addr[6:4] == 3'h2 || addr[6:4] == 3'h3))
    else $error("reserved encoding in base word");
  a_term_stop: assert property (tm |=> ##[0:2] !oe_dev ##1 !oe_dev)
    else $error("burst runs on after terminate");
endmodule
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the controller and device ends of the link.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        ref_clk;
  logic        reset;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [12:0] base_cfg;
  logic [12:0] extra_cfg;
  logic        normal;
  logic        busy;
  logic [8:0]  col;
  logic [15:0] rq[$];
  logic [8:0]  cq[$];
  int          mismatches;
  int          compares;

  sdram_link_if #(.DQ_W(16)) lnk ();
  sdram_cfg_host #(.DQ_W(16)) u_sdram_cfg_host (.REF_CLK(ref_clk),
    .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .link(lnk));
  sdram_cfg_device #(.DQ_W(16), .COL_W(9)) u_sdram_cfg_device (
    .REF_CLK(ref_clk), .RESET(reset), .link(lnk), .BASE_CONFIG(base_cfg),
    .EXTRA_CONFIG(extra_cfg), .NORMAL_MODE(normal), .BURST_BUSY(busy),
    .BURST_COLUMN(col));
  sdram_link_assertions u_sdram_link_assertions (.REF_CLK(ref_clk),
    .RESET(reset), .cs_n(lnk.cs_n), .ras_n(lnk.ras_n), .cas_n(lnk.cas_n),
    .we_n(lnk.we_n), .ba(lnk.ba), .addr(lnk.addr), .oe_host(lnk.oe_host),
    .oe_dev(lnk.oe_dev));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Every beat the device drives is collected at the edge that samples it.
  always @(posedge ref_clk) begin
    if (lnk.oe_dev === 1'b1) begin
      rq.push_back(lnk.dq);
      cq.push_back(col);
    end
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic cmd(input logic [2:0] op, input logic [1:0] b,
                     input logic [12:0] a);
    reg_wr(sdram_cfg_pkg::REG_CMD, {13'h0000, op, 1'b0, b, a});
  endtask

  task automatic wait_idle();
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      reg_rd(sdram_cfg_pkg::REG_STATUS, s);
      n++;
    end while (s[0] !== 1'b0 && n < 64);
    chk("idle", {31'h0, s[0]}, 32'h0);
  endtask

  task automatic load(input logic [1:0] b, input logic [12:0] w);
    cmd(sdram_cfg_pkg::OP_LOAD, b, w);
    wait_idle();
  endtask

  task automatic wr_burst(input logic [31:0] d, input logic [12:0] c);
    reg_wr(sdram_cfg_pkg::REG_WDATA, d);
    cmd(sdram_cfg_pkg::OP_WRITE, 2'h0, c);
    wait_idle();
  endtask

  task automatic do_rd(input logic [12:0] c);
    rq.delete();
    cq.delete();
    cmd(sdram_cfg_pkg::OP_READ, 2'h0, c);
    wait_idle();
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic t_config();
    logic [14:0] bad[8] = '{15'h2023, 15'h6023, 15'h0050, 15'h002F,
                            15'h0024, 15'h00A3, 15'h0423, 15'h4080};
    logic [31:0] s;
    chk("base reset", {19'h0, base_cfg}, 32'h0020);
    chk("extra reset", {19'h0, extra_cfg}, 32'h0000);
    load(sdram_cfg_pkg::BA_EXT, 13'h005A);
    chk("extra", {19'h0, extra_cfg}, 32'h005A);
    chk("base kept", {19'h0, base_cfg}, 32'h0020);
    foreach (bad[i]) begin
      cmd(sdram_cfg_pkg::OP_LOAD, bad[i][14:13], bad[i][12:0]);
      reg_rd(sdram_cfg_pkg::REG_STATUS, s);
      chk("refused", {31'h0, s[1]}, 32'h1);
      chk("base held", {19'h0, base_cfg}, 32'h0020);
      chk("extra held", {19'h0, extra_cfg}, 32'h005A);
    end
    reg_wr(4'h2, 32'h00040033);
    chk("normal", {31'h0, normal}, 32'h1);
    load(sdram_cfg_pkg::BA_BASE, 13'h0033);
    chk("base", {19'h0, base_cfg}, 32'h0033);
    $display("t_config done");
  endtask

  task automatic t_fill();
    logic [31:0] d;
    load(sdram_cfg_pkg::BA_BASE, 13'h0023);
    cmd(sdram_cfg_pkg::OP_ACTIVE, 2'h0, 13'h0001);
    wr_burst(32'h100, 13'h0000);
    wr_burst(32'h500, 13'h01F8);
    load(sdram_cfg_pkg::BA_BASE, 13'h0022);
    wr_burst(32'h300, 13'h0010);
    reg_rd(sdram_cfg_pkg::REG_WDATA, d);
    chk("wdata", d, 32'h300);
    cmd(sdram_cfg_pkg::OP_PRECH, 2'h0, 13'h0400);
    $display("t_fill done");
  endtask

  task automatic t_order();
    logic [12:0] cf[5] = '{13'h003B, 13'h0023, 13'h002A, 13'h0031,
                           13'h0030};
    int st[5] = '{5, 3, 6, 1, 7};
    int ln;
    int c;
    logic [31:0] d;
    foreach (cf[i]) begin
      ln = 1 << cf[i][1:0];
      load(sdram_cfg_pkg::BA_BASE, cf[i]);
      do_rd(13'(st[i]));
      chk("beats", 32'(rq.size()), 32'(ln));
      for (int k = 0; k < ln; k++) begin
        c = cf[i][3] ? (st[i] ^ k) : (st[i] + k);
        c = (st[i] & ~(ln - 1)) | (c & (ln - 1));
        chk("order", {16'h0, rq[k]}, 32'h100 + 32'(c));
        chk("column", {23'h0, cq[k]}, 32'(c));
      end
      reg_rd(sdram_cfg_pkg::REG_RDATA, d);
      chk("rdata", d, 32'h100 + 32'(c));
      reg_rd(sdram_cfg_pkg::REG_STATUS, d);
      chk("count", {24'h0, d[23:16]}, 32'(ln));
    end
    $display("t_order done");
  endtask

  task automatic t_single();
    int c;
    load(sdram_cfg_pkg::BA_BASE, 13'h0222);
    wr_burst(32'h200, 13'h0010);
    load(sdram_cfg_pkg::BA_BASE, 13'h0022);
    do_rd(13'h0011);
    chk("beats", 32'(rq.size()), 32'h4);
    for (int k = 0; k < 4; k++) begin
      c = (1 + k) & 3;
      chk("single", {16'h0, rq[k]},
          (c == 0) ? 32'h200 : 32'h300 + 32'(c));
    end
    $display("t_single done");
  endtask

  task automatic t_full();
    load(sdram_cfg_pkg::BA_BASE, 13'h0027);
    rq.delete();
    cmd(sdram_cfg_pkg::OP_READ, 2'h0, 13'h01FE);
    // A fixed wait keeps the terminate edge, and so the beat count, exact.
    repeat (5) @(posedge ref_clk);
    chk("busy", {31'h0, busy}, 32'h1);
    cmd(sdram_cfg_pkg::OP_TERM, 2'h0, 13'h0000);
    wait_idle();
    chk("page 0", {16'h0, rq[0]}, 32'h506);
    chk("page 1", {16'h0, rq[1]}, 32'h507);
    chk("page 2", {16'h0, rq[2]}, 32'h100);
    chk("page 3", {16'h0, rq[3]}, 32'h101);
    chk("stopped", {31'h0, lnk.oe_dev}, 32'h0);
    chk("short", 32'(rq.size()), 32'h7);
    chk("dev idle", {31'h0, busy}, 32'h0);
    $display("t_full done");
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    mismatches = 0;
    compares = 0;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    t_config();
    t_fill();
    t_order();
    t_single();
    t_full();
    summarize();
  end

  // The tests need well under two thousand cycles; five thousand is ample.
  initial begin
    #(5000 * 100);
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
